// ==== rtl/sscr_pkg.sv ====
// constants and types for the slot status and configuration registers
package sscr_pkg;
	localparam int unsigned REG_W = 16;
	localparam int unsigned SLOTS = 16;
	localparam logic [6:0] DEV_ADDR_DEF = 7'h42; // arbitrary default
	localparam logic [15:0] OFS_STATUS = 16'h0001;
	localparam logic [15:0] OFS_POPULATED = 16'h0002;
	localparam logic [15:0] OFS_TOKEN = 16'h0003;
	localparam logic [15:0] OFS_BUSY_MASK = 16'h0004;
	localparam logic [15:0] OFS_TRIG_MASK = 16'h0005;
	localparam logic [15:0] RST_POPULATED = 16'h0000;
	localparam logic [15:0] RST_TOKEN = 16'h0000;
	localparam logic [15:0] RST_BUSY_MASK = 16'h0000;
	localparam logic [15:0] RST_TRIG_MASK = 16'h0000;
	localparam logic [15:0] RST_STATUS = 16'h0000;
	localparam logic [15:0] RD_UNMAPPED = 16'h0000;
	localparam logic [3:0] RSV_HI = 4'h0;
	localparam logic RSV_B7 = 1'b0;
	// status field positions
	localparam int unsigned ST_B_FREQ_LO = 10;
	localparam int unsigned ST_A_FREQ_LO = 8;
	localparam int unsigned ST_BUSY = 6;
	localparam int unsigned ST_TRIG = 5;
	localparam int unsigned ST_PFAULT = 4;
	localparam int unsigned ST_A_LOL = 3;
	localparam int unsigned ST_A_LOS = 2;
	localparam int unsigned ST_B_LOL = 1;
	localparam int unsigned ST_B_LOS = 0;
	// detected clock frequency codes
	localparam logic [1:0] FREQ_UNDEF = 2'h0;
	localparam logic [1:0] FREQ_31M25 = 2'h1;
	localparam logic [1:0] FREQ_125M = 2'h2;
	localparam logic [1:0] FREQ_250M = 2'h3;
	// bit counter marks within one serial byte
	localparam logic [3:0] BIT_LAST = 4'h8;
	localparam logic [3:0] BIT_ACK = 4'h9;
	localparam logic [3:0] BIT_ZERO = 4'h0;
	localparam logic [3:0] BIT_ONE = 4'h1;

	typedef enum logic [2:0] {
		SSCR_IDLE = 3'h0,
		SSCR_DEV = 3'h1,
		SSCR_REG_HI = 3'h3,
		SSCR_REG_LO = 3'h2,
		SSCR_WR_HI = 3'h6,
		SSCR_WR_LO = 3'h7,
		SSCR_RD_HI = 3'h5,
		SSCR_RD_LO = 3'h4
	} sscr_state_t;

	typedef struct packed {
		logic [15:0] slot_busy;
		logic [15:0] slot_trig;
		logic [1:0] clock_b_freq;
		logic [1:0] clock_a_freq;
		logic power_fault;
		logic clock_a_lock_lost;
		logic clock_a_signal_lost;
		logic clock_b_lock_lost;
		logic clock_b_signal_lost;
	} sscr_pins_t;
endpackage

// ==== rtl/sscr_regs.sv ====
// serial-bus slave holding the module status and slot configuration registers
`timescale 1ns/1ns
`default_nettype none
module sscr_regs #(
	parameter logic [6:0] DEV_ADDR = sscr_pkg::DEV_ADDR_DEF
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	input wire sscr_pkg::sscr_pins_t pins,
	output logic [15:0] populated_slots,
	output logic [15:0] token_participation_mask,
	output logic busy_summary,
	output logic trig_summary
);
	sscr_pkg::sscr_pins_t pins_m_r;
	sscr_pkg::sscr_pins_t pins_s_r;
	logic [1:0] scl_m_r;
	logic [1:0] sda_m_r;
	logic scl_s_r;
	logic sda_s_r;
	logic scl_d_r;
	logic sda_d_r;
	logic [15:0] populated_r;
	logic [15:0] token_r;
	logic [15:0] busy_mask_r;
	logic [15:0] trig_mask_r;
	logic [15:0] status_r;
	logic [15:0] status_nxt;
	sscr_pkg::sscr_state_t state_r;
	sscr_pkg::sscr_state_t state_nxt;
	logic [3:0] cnt_r;
	logic [7:0] rx_r;
	logic [7:0] tx_r;
	logic [7:0] data_hi_r;
	logic [15:0] addr_r;
	logic [15:0] rd_addr;
	logic [15:0] rd_word;
	logic [7:0] tx_byte;
	logic rw_r;
	logic nack_r;
	logic oe_r;
	logic scl_rise;
	logic scl_fall;
	logic start_c;
	logic stop_c;
	logic rx_state;

	// two-flop synchronisers for the status pins, three flops for scl and sda
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pins_m_r <= '0;
			pins_s_r <= '0;
			scl_m_r <= 2'h3;
			sda_m_r <= 2'h3;
			scl_s_r <= 1'b1;
			sda_s_r <= 1'b1;
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else if (ce) begin
			pins_m_r <= pins;
			pins_s_r <= pins_m_r;
			scl_m_r <= {scl_m_r[0], scl_i};
			sda_m_r <= {sda_m_r[0], sda_i};
			scl_s_r <= scl_m_r[1];
			sda_s_r <= sda_m_r[1];
			scl_d_r <= scl_s_r;
			sda_d_r <= sda_s_r;
		end
	end

	assign scl_rise = scl_s_r & ~scl_d_r;
	assign scl_fall = ~scl_s_r & scl_d_r;
	assign start_c = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
	assign stop_c = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;
	assign rx_state = (state_r != sscr_pkg::SSCR_RD_HI) && (state_r != sscr_pkg::SSCR_RD_LO);

	// status word assembled from synchronised pins
	always_comb begin
		status_nxt = sscr_pkg::RST_STATUS;
		status_nxt[15:12] = sscr_pkg::RSV_HI;
		status_nxt[7] = sscr_pkg::RSV_B7;
		status_nxt[sscr_pkg::ST_B_FREQ_LO +: 2] = pins_s_r.clock_b_freq;
		status_nxt[sscr_pkg::ST_A_FREQ_LO +: 2] = pins_s_r.clock_a_freq;
		status_nxt[sscr_pkg::ST_BUSY] = |(pins_s_r.slot_busy & busy_mask_r);
		status_nxt[sscr_pkg::ST_TRIG] = |(pins_s_r.slot_trig & trig_mask_r);
		status_nxt[sscr_pkg::ST_PFAULT] = pins_s_r.power_fault;
		status_nxt[sscr_pkg::ST_A_LOL] = pins_s_r.clock_a_lock_lost;
		status_nxt[sscr_pkg::ST_A_LOS] = pins_s_r.clock_a_signal_lost;
		status_nxt[sscr_pkg::ST_B_LOL] = pins_s_r.clock_b_lock_lost;
		status_nxt[sscr_pkg::ST_B_LOS] = pins_s_r.clock_b_signal_lost;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			status_r <= sscr_pkg::RST_STATUS;
		end else if (ce) begin
			status_r <= status_nxt;
		end
	end

	// read data mux; a read in the low byte prefetches the next word
	assign rd_addr = (state_r == sscr_pkg::SSCR_RD_LO) ? 16'(addr_r + 16'h0001) : addr_r;
	always_comb begin
		unique case (rd_addr)
			sscr_pkg::OFS_STATUS: rd_word = status_r;
			sscr_pkg::OFS_POPULATED: rd_word = populated_r;
			sscr_pkg::OFS_TOKEN: rd_word = token_r;
			sscr_pkg::OFS_BUSY_MASK: rd_word = busy_mask_r;
			sscr_pkg::OFS_TRIG_MASK: rd_word = trig_mask_r;
			default: rd_word = sscr_pkg::RD_UNMAPPED;
		endcase
	end

	// state after the acknowledge bit
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			sscr_pkg::SSCR_IDLE: state_nxt = sscr_pkg::SSCR_IDLE;
			sscr_pkg::SSCR_DEV: state_nxt = rw_r ? sscr_pkg::SSCR_RD_HI : sscr_pkg::SSCR_REG_HI;
			sscr_pkg::SSCR_REG_HI: state_nxt = sscr_pkg::SSCR_REG_LO;
			sscr_pkg::SSCR_REG_LO: state_nxt = sscr_pkg::SSCR_WR_HI;
			sscr_pkg::SSCR_WR_HI: state_nxt = sscr_pkg::SSCR_WR_LO;
			sscr_pkg::SSCR_WR_LO: state_nxt = sscr_pkg::SSCR_WR_HI;
			sscr_pkg::SSCR_RD_HI: state_nxt = nack_r ? sscr_pkg::SSCR_IDLE : sscr_pkg::SSCR_RD_LO;
			sscr_pkg::SSCR_RD_LO: state_nxt = nack_r ? sscr_pkg::SSCR_IDLE : sscr_pkg::SSCR_RD_HI;
		endcase
	end

	assign tx_byte = (state_nxt == sscr_pkg::SSCR_RD_HI) ? rd_word[15:8] : rd_word[7:0];

	// byte engine: start, stop, bit shifting, acknowledge and transmit
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_r <= sscr_pkg::SSCR_IDLE;
			cnt_r <= sscr_pkg::BIT_ZERO;
			rx_r <= 8'h00;
			tx_r <= 8'h00;
			data_hi_r <= 8'h00;
			addr_r <= 16'h0000;
			rw_r <= 1'b0;
			nack_r <= 1'b0;
			oe_r <= 1'b0;
		end else if (ce) begin
			if (stop_c) begin
				state_r <= sscr_pkg::SSCR_IDLE;
				oe_r <= 1'b0;
			end else if (start_c) begin
				state_r <= sscr_pkg::SSCR_DEV;
				cnt_r <= sscr_pkg::BIT_ZERO;
				nack_r <= 1'b0;
				oe_r <= 1'b0;
			end else if (state_r != sscr_pkg::SSCR_IDLE) begin
				if (scl_rise) begin
					if (cnt_r < sscr_pkg::BIT_LAST) begin
						rx_r <= {rx_r[6:0], sda_s_r};
					end
					if (cnt_r == sscr_pkg::BIT_LAST) begin
						nack_r <= sda_s_r;
					end
					cnt_r <= 4'(cnt_r + sscr_pkg::BIT_ONE);
				end else if (scl_fall) begin
					if (cnt_r == sscr_pkg::BIT_LAST) begin
						oe_r <= rx_state;
						unique case (state_r)
							sscr_pkg::SSCR_DEV: begin
								rw_r <= rx_r[0];
								if (rx_r[7:1] != DEV_ADDR) begin
									state_r <= sscr_pkg::SSCR_IDLE;
									oe_r <= 1'b0;
								end
							end
							sscr_pkg::SSCR_REG_HI: addr_r[15:8] <= rx_r;
							sscr_pkg::SSCR_REG_LO: addr_r[7:0] <= rx_r;
							sscr_pkg::SSCR_WR_HI: data_hi_r <= rx_r;
							sscr_pkg::SSCR_WR_LO: addr_r <= 16'(addr_r + 16'h0001);
							default: begin
							end
						endcase
					end else if (cnt_r == sscr_pkg::BIT_ACK) begin
						cnt_r <= sscr_pkg::BIT_ZERO;
						state_r <= state_nxt;
						if (state_r == sscr_pkg::SSCR_RD_LO) begin
							addr_r <= 16'(addr_r + 16'h0001);
						end
						if (state_nxt == sscr_pkg::SSCR_RD_HI || state_nxt == sscr_pkg::SSCR_RD_LO) begin
							tx_r <= tx_byte;
							oe_r <= ~tx_byte[7];
						end else begin
							oe_r <= 1'b0;
						end
					end else if (!rx_state && cnt_r != sscr_pkg::BIT_ZERO) begin
						tx_r <= {tx_r[6:0], 1'b0};
						oe_r <= ~tx_r[6];
					end
				end
			end
		end
	end

	// register writes; status and unmapped offsets ignore writes
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			populated_r <= sscr_pkg::RST_POPULATED;
			token_r <= sscr_pkg::RST_TOKEN;
			busy_mask_r <= sscr_pkg::RST_BUSY_MASK;
			trig_mask_r <= sscr_pkg::RST_TRIG_MASK;
		end else if (ce && scl_fall && !stop_c && !start_c && cnt_r == sscr_pkg::BIT_LAST
				&& state_r == sscr_pkg::SSCR_WR_LO) begin
			unique case (addr_r)
				sscr_pkg::OFS_POPULATED: populated_r <= {data_hi_r, rx_r};
				sscr_pkg::OFS_TOKEN: token_r <= {data_hi_r, rx_r};
				sscr_pkg::OFS_BUSY_MASK: busy_mask_r <= {data_hi_r, rx_r};
				sscr_pkg::OFS_TRIG_MASK: trig_mask_r <= {data_hi_r, rx_r};
				default: begin
				end
			endcase
		end
	end

	// sda only ever pulls low
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sda_o <= 1'b0;
		end else if (ce) begin
			sda_o <= 1'b0;
		end
	end

	assign sda_oe = oe_r;
	assign populated_slots = populated_r;
	assign token_participation_mask = token_r;
	assign busy_summary = status_r[sscr_pkg::ST_BUSY];
	assign trig_summary = status_r[sscr_pkg::ST_TRIG];
endmodule
`default_nettype wire

// ==== tb/sscr_regs_chk.sv ====
// port assertions for the slot status registers
`timescale 1ns/1ns
`default_nettype none
module sscr_regs_chk (
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe,
	input wire sscr_pkg::sscr_pins_t pins,
	input wire logic [15:0] populated_slots,
	input wire logic [15:0] token_participation_mask,
	input wire logic busy_summary,
	input wire logic trig_summary
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence scl_quiet;
		scl_i [*7];
	endsequence
	busy_cause_a: assert property ($rose(busy_summary) |-> $past(|pins.slot_busy, 3)) else $error("busy cause");
	busy_idle_a: assert property ((pins.slot_busy == 16'h0) [*4] |-> !busy_summary) else $error("busy idle");
	trig_cause_a: assert property ($rose(trig_summary) |-> $past(|pins.slot_trig, 3)) else $error("trig cause");
	trig_idle_a: assert property ((pins.slot_trig == 16'h0) [*4] |-> !trig_summary) else $error("trig idle");
	ack_launch_a: assert property ($rose(sda_oe) |-> !scl_i) else $error("ack on high clock");
	open_drain_a: assert property (sda_o == 1'b0) else $error("data driven high");
	regs_hold_a: assert property (scl_quiet |-> $stable(populated_slots) && $stable(token_participation_mask))
		else $error("mask moved while bus idle");
	freeze_a: assert property (!ce |=> $stable(busy_summary) && $stable(trig_summary)) else $error("ce freeze");
endmodule
bind sscr_regs sscr_regs_chk chk (.clk, .nrst, .ce, .scl_i, .sda_i, .sda_o, .sda_oe, .pins, .populated_slots,
	.token_participation_mask, .busy_summary, .trig_summary);
`default_nettype wire

// ==== tb/sscr_master.sv ====
// serial bus master model for the slot registers
`timescale 1ns/1ns
`default_nettype none
module sscr_master (
	output logic scl,
	output logic sda_m,
	input wire logic sda
);
	localparam int H = 40;
	initial begin
		scl = 1'b1;
		sda_m = 1'b1;
	end
	task automatic xbit(input logic b, output logic r);
		#(H / 2) sda_m = b;
		#(H / 2) scl = 1'b1;
		#H r = sda;
		scl = 1'b0;
	endtask
	task automatic xbyte(input logic [7:0] d, input logic ai, output logic [7:0] q);
		logic a;
		for (int i = 7; i >= 0; i--) begin
			xbit(d[i], a);
			q = {q[6:0], a};
		end
		xbit(ai, a);
	endtask
	// start when s is low, stop when high
	task automatic cond(input logic s);
		#(H / 2) sda_m = !s;
		#(H / 2) scl = 1'b1;
		#H sda_m = s;
		#H scl = s;
	endtask
	task automatic head(input logic [15:0] a);
		logic [7:0] x;
		cond(1'b0);
		xbyte({sscr_pkg::DEV_ADDR_DEF, 1'b0}, 1'b1, x);
		xbyte(a[15:8], 1'b1, x);
		xbyte(a[7:0], 1'b1, x);
	endtask
	task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic two);
		logic [7:0] x;
		head(a);
		for (int i = 0; i < (two ? 4 : 2); i++) xbyte(d[31 - 8 * i -: 8], 1'b1, x);
		cond(1'b1);
	endtask
	task automatic rd(input logic [15:0] a, input logic two, output logic [31:0] q);
		logic [7:0] x;
		q = '0;
		head(a);
		cond(1'b0);
		xbyte({sscr_pkg::DEV_ADDR_DEF, 1'b1}, 1'b1, x);
		for (int i = 0; i < (two ? 4 : 2); i++) begin
			xbyte(8'hff, i == (two ? 3 : 1), x);
			q = {q[23:0], x};
		end
		cond(1'b1);
	endtask
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// self-checking bench for the slot status and configuration registers
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic ce = 1'b1;
	logic scl_i, sda_m, sda_o, sda_oe, busy_summary, trig_summary;
	logic [15:0] populated_slots, token_participation_mask;
	logic [31:0] q;
	wire sda_i = sda_m & ~sda_oe;
	sscr_pkg::sscr_pins_t pins = {32'h0, 2'h3, 2'h1, 5'b11010};
	int failures = 0;
	int tests_run = 0;
	logic [47:0] rows [6] = '{48'h0002a5c3a5c3, 48'h000380018001, 48'h000400ff00ff, 48'h0005ff00ff00,
		48'h0001ffff0d1a, 48'h000612340000};
	sscr_regs uut (.clk, .nrst, .ce, .scl_i, .sda_i, .sda_o, .sda_oe, .pins, .populated_slots,
		.token_participation_mask, .busy_summary, .trig_summary);
	sscr_master bus (.scl(scl_i), .sda_m, .sda(sda_i));
	always #2 clk = ~clk;
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) failures++;
		if (got !== exp) $display("BAD %0t got %h want %h", $time, got, exp);
	endtask
	task automatic conclude();
		$display("checks %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		#200000;
		failures++;
		conclude();
	end
	initial begin
		repeat (3) @(negedge clk);
		nrst = 1'b1;
		repeat (5) @(negedge clk);
		bus.rd(16'h0002, 1'b1, q);
		chk(q[31:16], 16'h0000);
		chk(q[15:0], 16'h0000);
		foreach (rows[i]) begin
			bus.wr(rows[i][47:32], {rows[i][31:16], 16'h0000}, 1'b0);
			bus.rd(rows[i][47:32], 1'b0, q);
			chk(q[15:0], rows[i][15:0]);
		end
		bus.wr(16'h0002, 32'h00018000, 1'b1);
		chk(populated_slots, 16'h0001);
		chk(token_participation_mask, 16'h8000);
		for (int i = 0; i < 4; i++) begin
			pins.clock_a_freq = 2'(i);
			pins.clock_b_freq = 2'(3 - i);
			{pins.clock_a_lock_lost, pins.clock_b_signal_lost} = {i[0], i[1]};
			bus.rd(16'h0001, 1'b0, q);
			chk(q[15:0], {4'h0, 2'(3 - i), 2'(i), 4'h1, i[0], 2'b01, i[1]});
		end
		{pins.slot_busy, pins.slot_trig} = 32'h01000100;
		repeat (6) @(negedge clk);
		chk({14'h0, busy_summary, trig_summary}, 16'h0001);
		{pins.slot_busy, pins.slot_trig} = 32'h00010001;
		bus.rd(16'h0001, 1'b0, q);
		chk(q[15:0], 16'h035b);
		ce = 1'b0;
		pins.slot_trig = 16'h8000;
		repeat (6) @(negedge clk);
		chk({14'h0, busy_summary, trig_summary}, 16'h0002);
		ce = 1'b1;
		repeat (6) @(negedge clk);
		chk({14'h0, busy_summary, trig_summary}, 16'h0003);
		conclude();
	end
endmodule
`default_nettype wire
